// File: dual_adc_consts.svh
// What this block does
// - conversion advances only on host serial clock edges, no internal clock.
// - frame select falling samples both inputs, starts conversion, drives both outputs.
// - after 13 falling edges, sampler returns to track on next rising edge.
// - a 16-clock frame shifts two zeros after the last result bit.
// - frame select rising aborts conversion and releases both outputs.
// - held low further clocks, line a then shifts converter b's result.
// - held low further clocks, line b then shifts converter a's result.
// - extended frame releases the line at 32nd falling edge or frame end.
// - first leading zero appears as soon as frame select falls.
// - each later falling edge shifts next bit; first gives second zero.
// - 12-bit result follows MSB first, last bit launched at 13th fall.
// - rising edges before the first falling edge are ignored.
// - a falling edge coincident with frame select falling is not counted.
// - frame ended after 2nd, before 10th fall enters partial power-down.
// - frame ended before 2nd falling edge leaves power state unchanged.
// - from partial power-down, a frame ended after 2nd, before 10th fall enters full power-down.
// - frame held past 10th fall powers up; its result is a dummy.
`ifndef DUAL_ADC_CONSTS_SVH
`define DUAL_ADC_CONSTS_SVH

// ==========================================================
// result format
`define RES_W         12
`define LEAD_ZEROS    2

// ==========================================================
// falling edge counts within a frame
`define FALL_TRACK    6'h0d
`define FALL_PD_LO    6'h02
`define FALL_PD_HI    6'h0a
`define FALL_END      6'h20
`define FALL_CNT_W    6

// ==========================================================
// reset values
`define PIN_IDLE      1'b1
`define TRACK_RST     1'b1

`endif

// File: dual_adc_pkg.sv
package dual_adc_pkg;

    // ==========================================================
    // power states
    typedef enum logic [1:0] {
        pwr_normal  = 2'b00,
        pwr_partial = 2'b01,
        pwr_full    = 2'b10
    } pwr_state_t;

endpackage : dual_adc_pkg

// File: lane_if.sv
`timescale 1ns/1ps
`default_nettype none

interface lane_if #(
    parameter int unsigned W = 12
);
    logic         load;
    logic         shift;
    logic [W-1:0] first;
    logic [W-1:0] second;
    logic         bit_out;

    modport ctrl (output load, output shift, output first, output second, input bit_out);
    modport lane (input load, input shift, input first, input second, output bit_out);
endinterface : lane_if

`default_nettype wire

// File: lane_shifter.sv
`timescale 1ns/1ps
`default_nettype none
`include "dual_adc_consts.svh"

module lane_shifter #(
    parameter int unsigned W = `RES_W
) (
    // clock, reset and freeze
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic clk_en,
    // control from the frame logic
    lane_if.lane      port
);
    localparam int unsigned LZ = `LEAD_ZEROS;
    localparam int unsigned FW = 2 * W + 4 * LZ;

    logic [FW-1:0] sr;
    logic [FW-1:0] next_sr;
    logic [FW-1:0] word;
    logic          out_bit;
    logic          next_out_bit;

    // ==========================================================
    // frame word: zeros, own result, zeros, zeros, other result, zeros
    assign word = {{LZ{1'b0}}, port.first, {(2*LZ){1'b0}}, port.second, {LZ{1'b0}}};

    always_comb begin
        next_sr      = sr;
        next_out_bit = out_bit;
        if (port.load) begin
            next_out_bit = word[FW-1];
            next_sr      = {word[FW-2:0], 1'b0};
        end else if (port.shift) begin
            next_out_bit = sr[FW-1];
            next_sr      = {sr[FW-2:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sr      <= '0;
            out_bit <= 1'b0;
        end else if (clk_en) begin
            sr      <= next_sr;
            out_bit <= next_out_bit;
        end
    end

    assign port.bit_out = out_bit;

endmodule : lane_shifter

`default_nettype wire

// File: dual_adc_serial_readout.sv
`timescale 1ns/1ps
`default_nettype none
`include "dual_adc_consts.svh"

module dual_adc_serial_readout #(
    parameter int unsigned RES_W = `RES_W
) (
    // clock, reset and freeze
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic             clk_en,
    // host link pins
    input  wire logic             frame_sel_n,
    input  wire logic             serial_clk,
    output logic                  serial_out_a,
    output logic                  serial_out_a_oe_n,
    output logic                  serial_out_b,
    output logic                  serial_out_b_oe_n,
    // converter core
    input  wire logic [RES_W-1:0] conv_a,
    input  wire logic [RES_W-1:0] conv_b,
    output logic                  track,
    output dual_adc_pkg::pwr_state_t power_state,
    output logic                  dummy_frame
);

    // ==========================================================
    // pin synchronisers
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;

    // both pins are asynchronous; link edges are found by the system clock
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cs_m   <= `PIN_IDLE;
            cs_s   <= `PIN_IDLE;
            cs_d   <= `PIN_IDLE;
            sclk_m <= `PIN_IDLE;
            sclk_s <= `PIN_IDLE;
            sclk_d <= `PIN_IDLE;
        end else if (clk_en) begin
            cs_m   <= frame_sel_n;
            cs_s   <= cs_m;
            cs_d   <= cs_s;
            sclk_m <= serial_clk;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
        end
    end

    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic sclk_rise;
    logic count_fall;

    assign cs_fall   = cs_d & ~cs_s;
    assign cs_rise   = ~cs_d & cs_s;
    assign sclk_fall = sclk_d & ~sclk_s;
    assign sclk_rise = ~sclk_d & sclk_s;

    // ==========================================================
    // frame state
    logic                           active;
    logic                           next_active;
    logic [`FALL_CNT_W-1:0]         fcnt;
    logic [`FALL_CNT_W-1:0]         next_fcnt;
    logic                           next_track;
    logic                           drive;
    logic                           next_drive;
    logic                           next_dummy;
    dual_adc_pkg::pwr_state_t       pwr;
    dual_adc_pkg::pwr_state_t       next_pwr;

    lane_if #(.W(RES_W)) lane_a ();
    lane_if #(.W(RES_W)) lane_b ();

    function automatic dual_adc_pkg::pwr_state_t deeper(input dual_adc_pkg::pwr_state_t p);
        case (p)
            dual_adc_pkg::pwr_normal: deeper = dual_adc_pkg::pwr_partial;
            default:                  deeper = dual_adc_pkg::pwr_full;
        endcase
    endfunction : deeper

    // only edges counted while the frame is open; the sequence is paced
    // purely by link edges, never by a free-running timer
    assign count_fall = active & sclk_fall & ~cs_fall & ~cs_rise
                        & (fcnt < `FALL_END);

    always_comb begin
        next_active  = active;
        next_fcnt    = fcnt;
        next_track   = track;
        next_drive   = drive;
        next_dummy   = dummy_frame;
        next_pwr     = pwr;
        lane_a.load  = 1'b0;
        lane_a.shift = 1'b0;
        if (cs_rise) begin
            // abort: outputs released, sampler back to track
            next_active = 1'b0;
            next_drive  = 1'b0;
            next_track  = 1'b1;
            // short glitches below the second fall leave the power state unchanged
            if (active && fcnt >= `FALL_PD_LO && fcnt < `FALL_PD_HI) begin
                next_pwr = deeper(pwr);
            end
        end else if (cs_fall) begin
            next_active = 1'b1;
            next_fcnt   = '0;
            next_drive  = 1'b1;
            next_track  = 1'b0;
            next_dummy  = (pwr != dual_adc_pkg::pwr_normal);
            lane_a.load = 1'b1;
        end else if (count_fall) begin
            next_fcnt    = fcnt + 1'b1;
            lane_a.shift = 1'b1;
            if (next_fcnt == `FALL_END) begin
                next_drive = 1'b0;
            end
            if (next_fcnt == `FALL_PD_HI) begin
                next_pwr = dual_adc_pkg::pwr_normal;
            end
        end else if (sclk_rise && active && fcnt >= `FALL_TRACK) begin
            // rising edges before the first fall leave fcnt at zero here
            next_track = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            active      <= 1'b0;
            fcnt        <= '0;
            track       <= `TRACK_RST;
            drive       <= 1'b0;
            dummy_frame <= 1'b0;
            pwr         <= dual_adc_pkg::pwr_normal;
        end else if (clk_en) begin
            active      <= next_active;
            fcnt        <= next_fcnt;
            track       <= next_track;
            drive       <= next_drive;
            dummy_frame <= next_dummy;
            pwr         <= next_pwr;
        end
    end

    // ==========================================================
    // output lanes: each shows its own result, then the other one
    assign lane_a.first  = conv_a;
    assign lane_a.second = conv_b;
    assign lane_b.load   = lane_a.load;
    assign lane_b.shift  = lane_a.shift;
    assign lane_b.first  = conv_b;
    assign lane_b.second = conv_a;

    lane_shifter #(.W(RES_W)) u_lane_a (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clk_en  (clk_en),
        .port    (lane_a.lane)
    );

    lane_shifter #(.W(RES_W)) u_lane_b (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clk_en  (clk_en),
        .port    (lane_b.lane)
    );

    assign serial_out_a      = lane_a.bit_out;
    assign serial_out_b      = lane_b.bit_out;
    assign serial_out_a_oe_n = ~drive;
    assign serial_out_b_oe_n = ~drive;
    assign power_state       = pwr;

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    property p_frame_start_drives;
        clk_en && cs_fall |=> !serial_out_a_oe_n && !serial_out_b_oe_n && !track;
    endproperty
    a_frame_start_drives: assert property (p_frame_start_drives)
        else $error("outputs not driven after frame start");

    property p_first_zero;
        clk_en && cs_fall |=> serial_out_a == 1'b0 && serial_out_b == 1'b0 && fcnt == 6'h00;
    endproperty
    a_first_zero: assert property (p_first_zero)
        else $error("first leading zero missing");

    property p_abort_release;
        clk_en && cs_rise |=> serial_out_a_oe_n && serial_out_b_oe_n && !active;
    endproperty
    a_abort_release: assert property (p_abort_release)
        else $error("outputs not released at frame end");

    property p_track_after_13;
        clk_en && sclk_rise && active && !cs_rise && !cs_fall && fcnt >= 6'h0d |=> track;
    endproperty
    a_track_after_13: assert property (p_track_after_13)
        else $error("sampler did not return to track");

    property p_hold_before_13;
        clk_en && active && !cs_rise && fcnt < 6'h0d |=> !track;
    endproperty
    a_hold_before_13: assert property (p_hold_before_13)
        else $error("sampler tracked too early");

    property p_release_at_32;
        clk_en && count_fall && fcnt == 6'h1f |=> serial_out_a_oe_n && fcnt == 6'h20;
    endproperty
    a_release_at_32: assert property (p_release_at_32)
        else $error("line not released at 32nd fall");

    property p_coincident_fall;
        clk_en && cs_fall && sclk_fall |=> fcnt == 6'h00;
    endproperty
    a_coincident_fall: assert property (p_coincident_fall)
        else $error("coincident falling edge was counted");

    property p_partial_entry;
        clk_en && cs_rise && active && fcnt >= 6'h02 && fcnt < 6'h0a
            && pwr == dual_adc_pkg::pwr_normal |=> pwr == dual_adc_pkg::pwr_partial;
    endproperty
    a_partial_entry: assert property (p_partial_entry)
        else $error("partial power-down not entered");

    property p_full_entry;
        clk_en && cs_rise && active && fcnt >= 6'h02 && fcnt < 6'h0a
            && pwr == dual_adc_pkg::pwr_partial |=> pwr == dual_adc_pkg::pwr_full;
    endproperty
    a_full_entry: assert property (p_full_entry)
        else $error("full power-down not entered");

    property p_glitch_ignored;
        clk_en && cs_rise && fcnt < 6'h02 |=> $stable(pwr);
    endproperty
    a_glitch_ignored: assert property (p_glitch_ignored)
        else $error("power state changed on short frame");

    property p_power_up;
        clk_en && count_fall && fcnt == 6'h09 |=> pwr == dual_adc_pkg::pwr_normal;
    endproperty
    a_power_up: assert property (p_power_up)
        else $error("device did not power up at 10th fall");

    property p_shift_step;
        clk_en && count_fall |=> fcnt == $past(fcnt) + 6'h01 ##1 !serial_out_a_oe_n || fcnt >= 6'h20 || !active;
    endproperty
    a_shift_step: assert property (p_shift_step)
        else $error("falling edge did not advance the bit count");

    c_full_frame:   cover property (clk_en && count_fall && fcnt == 6'h0f);
    c_dual_result:  cover property (clk_en && count_fall && fcnt == 6'h1f);
    c_power_down:   cover property (pwr == dual_adc_pkg::pwr_full);
    c_power_up:     cover property (clk_en && count_fall && fcnt == 6'h09 && dummy_frame);

endmodule : dual_adc_serial_readout

`default_nettype wire

// File: host_link_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_link_model (
    // clock
    input  wire logic sys_clk,
    // link pins
    output logic      frame_sel_n,
    output logic      serial_clk,
    input  wire logic serial_out_a,
    input  wire logic serial_out_a_oe_n,
    input  wire logic serial_out_b,
    input  wire logic serial_out_b_oe_n,
    // sampler state seen by the host
    input  wire logic track
);
    // ==========================================================
    // captured bits, index k is the bit seen after k falls
    logic cap_a [0:32];
    logic cap_b [0:32];
    logic trk   [0:32];
    logic line_a;
    logic line_b;

    // no pull on the lines: a released line reads as floating
    assign line_a = serial_out_a_oe_n ? 1'bz : serial_out_a;
    assign line_b = serial_out_b_oe_n ? 1'bz : serial_out_b;

    // serial clock stands high between frames, except in the last 10 cycles before a mode 2 frame
    initial begin
        frame_sel_n = 1'b1;
        serial_clk  = 1'b1;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    task automatic grab(input int k);
        cap_a[k] = line_a;
        cap_b[k] = line_b;
    endtask : grab

    // ==========================================================
    // mode 0 plain, 1 clock falls with select, 2 early rising edge
    task automatic run_frame(input int n, input int mode);
        if (mode == 2) begin
            serial_clk = 1'b0;
            cyc(10);
        end
        frame_sel_n = 1'b0;
        if (mode == 1) begin
            serial_clk = 1'b0;
        end
        if (mode != 0) begin
            cyc(mode == 1 ? 5 : 3);
            serial_clk = 1'b1;
        end
        cyc(6);
        grab(0);
        trk[0] = track;
        // 80 ns period; word length 1, 8, 14, 16 or 32 clocks
        for (int k = 1; k <= n; k++) begin
            serial_clk = 1'b0;
            cyc(5);
            serial_clk = 1'b1;
            cyc(2);
            grab(k);
            cyc(3);
            trk[k] = track;
        end
        frame_sel_n = 1'b1;
        // fixed gap holds frame select high for 12 cycles between frames
        cyc(12);
    endtask : run_frame
endmodule : host_link_model

`default_nettype wire

// File: dual_adc_serial_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none

module dual_adc_serial_readout_tb;
    logic                     sys_clk;
    logic                     nrst;
    logic                     clk_en;
    logic                     frame_sel_n;
    logic                     serial_clk;
    logic                     serial_out_a;
    logic                     serial_out_a_oe_n;
    logic                     serial_out_b;
    logic                     serial_out_b_oe_n;
    logic [11:0]              conv_a;
    logic [11:0]              conv_b;
    logic                     track;
    dual_adc_pkg::pwr_state_t power_state;
    logic                     dummy_frame;
    logic                     dummy_seen;
    int                       num_errors;
    int                       compares;

    dual_adc_serial_readout dual_adc_serial_readout_i (
        .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .frame_sel_n(frame_sel_n),
        .serial_clk(serial_clk), .serial_out_a(serial_out_a),
        .serial_out_a_oe_n(serial_out_a_oe_n), .serial_out_b(serial_out_b),
        .serial_out_b_oe_n(serial_out_b_oe_n), .conv_a(conv_a), .conv_b(conv_b),
        .track(track), .power_state(power_state), .dummy_frame(dummy_frame)
    );

    host_link_model host_link_model_i (
        .sys_clk(sys_clk), .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
        .serial_out_a(serial_out_a), .serial_out_a_oe_n(serial_out_a_oe_n),
        .serial_out_b(serial_out_b), .serial_out_b_oe_n(serial_out_b_oe_n), .track(track)
    );

    always #4 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (dummy_frame === 1'b1) begin
            dummy_seen <= 1'b1;
        end
    end

    // ==========================================================
    // shared checks
    task automatic stop_test();
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // word on a line: 0,0, own result, 0 x4, other result, 0,0
    function automatic logic exp_bit(input int k, input logic [11:0] own,
                                     input logic [11:0] oth);
        if (k >= 2 && k <= 13) begin
            return own[13-k];
        end
        if (k >= 18 && k <= 29) begin
            return oth[29-k];
        end
        return 1'b0;
    endfunction : exp_bit

    task automatic run_chk(input int n, input int mode, input logic [11:0] a,
                           input logic [11:0] b);
        conv_a     = a;
        conv_b     = b;
        dummy_seen = 1'b0;
        host_link_model_i.run_frame(n, mode);
        for (int k = 0; k <= (n > 31 ? 31 : n); k++) begin
            chk(host_link_model_i.cap_a[k], exp_bit(k, a, b));
            chk(host_link_model_i.cap_b[k], exp_bit(k, b, a));
        end
        chk(serial_out_a_oe_n, 1'b1);
        chk(serial_out_b_oe_n, 1'b1);
    endtask : run_chk

    // ==========================================================
    // scenarios
    task automatic t_reset_vals();
        chk({serial_out_a_oe_n, serial_out_b_oe_n, track, dummy_frame}, 8'h0e);
        chk({6'h00, power_state}, 8'h00);
    endtask : t_reset_vals

    task automatic t_single16();
        run_chk(16, 0, 12'ha5c, 12'h3c1);
        for (int k = 0; k <= 16; k++) begin
            chk(host_link_model_i.trk[k], k >= 13);
        end
        chk(dummy_seen, 1'b0);
    endtask : t_single16

    task automatic t_dual32();
        run_chk(32, 0, 12'h801, 12'h7fe);
        chk(host_link_model_i.cap_a[32], 1'bz);
        chk(host_link_model_i.cap_b[32], 1'bz);
    endtask : t_dual32

    task automatic t_edge_cases();
        run_chk(16, 1, 12'h123, 12'hedc);
        run_chk(14, 2, 12'hf0f, 12'h0f0);
    endtask : t_edge_cases

    task automatic t_power();
        int             len [5] = '{1, 8, 8, 1, 16};
        logic [7:0]     st  [5] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h00};
        for (int i = 0; i < 5; i++) begin
            run_chk(len[i], 0, 12'h5a5, 12'ha5a);
            chk({6'h00, power_state}, st[i]);
        end
        chk(dummy_seen, 1'b1);
    endtask : t_power

    task automatic t_mid_reset();
        run_chk(8, 0, 12'h0ff, 12'hf00);
        chk({6'h00, power_state}, 8'h01);
        nrst = 1'b0;
        @(negedge sys_clk);
        nrst = 1'b1;
        @(negedge sys_clk);
        t_reset_vals();
        // a full frame right after the second reset must read back cleanly
        run_chk(16, 0, 12'h3a7, 12'hc58);
        chk(dummy_seen, 1'b0);
    endtask : t_mid_reset

    // ==========================================================
    // main sequence and watchdog
    initial begin
        sys_clk    = 1'b0;
        nrst       = 1'b0;
        clk_en     = 1'b1;
        conv_a     = 12'h000;
        conv_b     = 12'h000;
        dummy_seen = 1'b0;
        num_errors = 0;
        compares   = 0;
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        @(negedge sys_clk);
        t_reset_vals();
        t_single16();
        t_dual32();
        t_edge_cases();
        t_power();
        t_mid_reset();
        stop_test();
    end

    initial begin
        repeat (50000) @(posedge sys_clk);
        num_errors++;
        stop_test();
    end
endmodule : dual_adc_serial_readout_tb

`default_nettype wire
